// ===== emicfg_pkg.sv
/*
  Shared constants and types of the external memory interface configuration
  block: register addresses, field positions, reset values, mode codes,
  state codes and the packed state records of both modules.
  Assumes a processor data bus with 16-bit byte addresses and 8-bit data.
*/
// How it works
// - An 8-bit bank map register resizes the split of the two memory spaces and resets to 8'h01.
// - Bits 7:6 of control register A give the read strobe wait states and reset to zero.
// - Bits 5:4 of control register A pick the read strobe waveform mode.
// - Bits 3:2 of control register A give the write strobe wait states and reset to zero.
// - Bits 1:0 of control register A pick the write strobe waveform mode.
// - Bits 7:6 of control register B give the address latch strobe wait states.
// - Bits 5:4 of control register B pick the address latch strobe waveform mode.
// - The mode field has its high bit at position 0 and low bit at 1; 00 FIFO, 01 reserved, 10 demux, 11 mux.
package emicfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_BANK_MAP = 16'hf800;
  localparam logic [15:0] ADDR_CTRL_A = 16'hf801;
  localparam logic [15:0] ADDR_CTRL_B = 16'hf802;
  localparam logic [7:0] RST_BANK_MAP = 8'h01;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RD_WAIT_LSB = 6;
  localparam int RD_WAVE_LSB = 4;
  localparam int WR_WAIT_LSB = 2;
  localparam int WR_WAVE_LSB = 0;
  localparam int ALE_WAIT_LSB = 6;
  localparam int ALE_WAVE_LSB = 4;
  localparam int MODE_HI_POS = 0;
  localparam int MODE_LO_POS = 1;

  // ****************************************
  // Interface mode codes
  // ****************************************
  localparam logic [1:0] MODE_FIFO = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_DEMUX = 2'h2;
  localparam logic [1:0] MODE_MUX = 2'h3;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    EMICFG_IDLE = 3'h1,
    EMICFG_ALE = 3'h2,
    EMICFG_STRB = 3'h4
  } emicfg_state_t;

  typedef struct packed {
    logic active;
    logic [1:0] cnt;
  } emicfg_tmr_t;

  typedef struct packed {
    emicfg_state_t state;
    logic [7:0] bank_map;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] rdata;
    logic is_write;
    logic [1:0] data_wait;
    logic busy;
    logic done;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [1:0] mode;
    logic [1:0] rd_wave;
    logic [1:0] wr_wave;
    logic [1:0] ale_wave;
  } emicfg_top_t;

endpackage : emicfg_pkg

// ===== emicfg_strobe_timer.sv
/*
  Strobe stretch timer: once started it stays active for one cycle plus the
  loaded number of wait cycles and flags the last active cycle.
  Assumes the caller starts it only once the previous stretch has reached its last cycle.
*/
module emicfg_strobe_timer #(
  parameter int WAIT_W = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic [WAIT_W-1:0] wait_cnt,
  output logic last
);

  emicfg_pkg::emicfg_tmr_t st;
  emicfg_pkg::emicfg_tmr_t next_st;

  // Loads the wait count on start and counts it down while active.
  always_comb
  begin
    next_st = st;
    if (start)
    begin
      next_st.active = 1'b1;
      next_st.cnt = 2'(wait_cnt);
    end
    else if (st.active)
    begin
      if (st.cnt == '0)
        next_st.active = 1'b0;
      else
        next_st.cnt = st.cnt - 2'h1;
    end
  end

  // Registers the timer state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  // The last stretched cycle of the strobe.
  assign last = st.active && (st.cnt == '0);

endmodule : emicfg_strobe_timer

// ===== emicfg_top.sv
/*
  External memory interface configuration: three processor registers and a
  strobe sequencer that applies their settings to each external access.
  Assumes processor bus requests are synchronous to clk_sys and that an
  access request is only made while acc_busy is low.
*/
module emicfg_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_we,
  input wire logic cpu_re,
  output logic [7:0] cpu_rdata,
  input wire logic acc_start,
  input wire logic acc_write,
  output logic acc_busy,
  output logic acc_done,
  output logic ale_strobe,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic [7:0] memory_bank_map,
  output logic [1:0] iface_mode,
  output logic [1:0] rd_wave,
  output logic [1:0] wr_wave,
  output logic [1:0] ale_wave
);

  // ****************************************
  // Register decode
  // ****************************************

  // Gives a one-hot select of the register at an address, zero if unmapped.
  function automatic logic [2:0] reg_sel(input logic [15:0] addr);
    reg_sel = {addr == emicfg_pkg::ADDR_CTRL_B, addr == emicfg_pkg::ADDR_CTRL_A,
               addr == emicfg_pkg::ADDR_BANK_MAP};
  endfunction : reg_sel

  emicfg_pkg::emicfg_top_t st;
  emicfg_pkg::emicfg_top_t next_st;
  logic tmr_start;
  logic [1:0] tmr_wait;
  logic tmr_last;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic is_mux;

  assign wsel = reg_sel(cpu_addr);
  assign rsel = reg_sel(cpu_addr);
  assign is_mux = (st.mode == emicfg_pkg::MODE_MUX);

  // ****************************************
  // Next state
  // ****************************************

  // Register writes, readback, and the access sequence with its snapshot.
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    tmr_start = 1'b0;
    tmr_wait = 2'h0;
    if (cpu_we && wsel[0])
      next_st.bank_map = cpu_wdata;
    if (cpu_we && wsel[1])
      next_st.ctrl_a = cpu_wdata;
    if (cpu_we && wsel[2])
      next_st.ctrl_b = cpu_wdata;
    if (cpu_re)
      next_st.rdata = rsel[0] ? st.bank_map : rsel[1] ? st.ctrl_a : rsel[2] ? st.ctrl_b
                      : emicfg_pkg::RDATA_UNMAPPED;
    // Mode follows the register with its high bit at position 0.
    next_st.mode = {st.ctrl_b[emicfg_pkg::MODE_HI_POS], st.ctrl_b[emicfg_pkg::MODE_LO_POS]};
    unique case (st.state)
      emicfg_pkg::EMICFG_IDLE:
      begin
        if (acc_start)
        begin
          // Settings are frozen here for the whole access.
          next_st.is_write = acc_write;
          next_st.rd_wave = st.ctrl_a[emicfg_pkg::RD_WAVE_LSB +: 2];
          next_st.wr_wave = st.ctrl_a[emicfg_pkg::WR_WAVE_LSB +: 2];
          next_st.ale_wave = st.ctrl_b[emicfg_pkg::ALE_WAVE_LSB +: 2];
          next_st.data_wait = acc_write ? st.ctrl_a[emicfg_pkg::WR_WAIT_LSB +: 2]
                              : st.ctrl_a[emicfg_pkg::RD_WAIT_LSB +: 2];
          tmr_start = 1'b1;
          if (is_mux)
          begin
            // Only the multiplexed bus needs an address latch phase.
            next_st.state = emicfg_pkg::EMICFG_ALE;
            tmr_wait = st.ctrl_b[emicfg_pkg::ALE_WAIT_LSB +: 2];
          end
          else
          begin
            next_st.state = emicfg_pkg::EMICFG_STRB;
            tmr_wait = acc_write ? st.ctrl_a[emicfg_pkg::WR_WAIT_LSB +: 2]
                       : st.ctrl_a[emicfg_pkg::RD_WAIT_LSB +: 2];
          end
        end
      end
      emicfg_pkg::EMICFG_ALE:
      begin
        if (tmr_last)
        begin
          next_st.state = emicfg_pkg::EMICFG_STRB;
          tmr_start = 1'b1;
          tmr_wait = st.data_wait;
        end
      end
      emicfg_pkg::EMICFG_STRB:
      begin
        if (tmr_last)
        begin
          next_st.state = emicfg_pkg::EMICFG_IDLE;
          next_st.done = 1'b1;
        end
      end
      default:
        next_st.state = emicfg_pkg::EMICFG_IDLE;
    endcase
    // Strobe flops follow the coming state so they stand for the full stretch.
    next_st.busy = (next_st.state != emicfg_pkg::EMICFG_IDLE);
    next_st.ale = (next_st.state == emicfg_pkg::EMICFG_ALE);
    next_st.rd_n = !((next_st.state == emicfg_pkg::EMICFG_STRB) && !next_st.is_write);
    next_st.wr_n = !((next_st.state == emicfg_pkg::EMICFG_STRB) && next_st.is_write);
  end

  // Registers all state; reset gives FIFO mode and unstretched strobes.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
      st.state <= emicfg_pkg::EMICFG_IDLE;
      st.bank_map <= emicfg_pkg::RST_BANK_MAP;
      st.ctrl_a <= emicfg_pkg::RST_CTRL_A;
      st.ctrl_b <= emicfg_pkg::RST_CTRL_B;
      st.rd_n <= 1'b1;
      st.wr_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Stretch timer shared by the latch and data strobe phases.
  emicfg_strobe_timer #(
    .WAIT_W(2)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(tmr_start),
    .wait_cnt(tmr_wait),
    .last(tmr_last)
  );

  // Outputs straight from the state flops.
  assign cpu_rdata = st.rdata;
  assign acc_busy = st.busy;
  assign acc_done = st.done;
  assign ale_strobe = st.ale;
  assign rd_strobe_n = st.rd_n;
  assign wr_strobe_n = st.wr_n;
  assign memory_bank_map = st.bank_map;
  assign iface_mode = st.mode;
  assign rd_wave = st.rd_wave;
  assign wr_wave = st.wr_wave;
  assign ale_wave = st.ale_wave;

  // ****************************************
  // Checks
  // ****************************************

  logic go_rd;
  logic go_wr;
  assign go_rd = acc_start && !st.busy && !acc_write && !is_mux;
  assign go_wr = acc_start && !st.busy && acc_write && !is_mux;

  sequence rd_low3;
    !rd_strobe_n [*3] ##1 rd_strobe_n;
  endsequence

  sequence wr_low1;
    !wr_strobe_n ##1 wr_strobe_n;
  endsequence

  sequence ale_high2;
    ale_strobe [*2] ##1 !ale_strobe;
  endsequence

  bank_reset_a: assert property (@(posedge clk_sys) $fell(srst) |->
    memory_bank_map == emicfg_pkg::RST_BANK_MAP && iface_mode == emicfg_pkg::MODE_FIFO)
    else $error("bank map or mode wrong after reset");
  bank_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_we && cpu_addr == emicfg_pkg::ADDR_BANK_MAP |=> memory_bank_map == $past(cpu_wdata))
    else $error("bank map write lost");
  read_wait_reset_a: assert property (@(posedge clk_sys) $fell(srst) |-> st.ctrl_a[7:6] == 2'h0)
    else $error("read wait not zero after reset");
  read_stretch_a: assert property (@(posedge clk_sys) disable iff (srst)
    go_rd && st.ctrl_a[7:6] == 2'h2 |=> rd_low3)
    else $error("read strobe length wrong");
  read_wave_a: assert property (@(posedge clk_sys) disable iff (srst)
    acc_start && !st.busy |=> rd_wave == $past(st.ctrl_a[5:4]))
    else $error("read wave not captured");
  write_plain_a: assert property (@(posedge clk_sys) disable iff (srst)
    go_wr && st.ctrl_a[3:2] == 2'h0 |=> wr_low1)
    else $error("write strobe not one cycle");
  write_wave_a: assert property (@(posedge clk_sys) disable iff (srst)
    acc_start && !st.busy |=> wr_wave == $past(st.ctrl_a[1:0]))
    else $error("write wave not captured");
  latch_stretch_a: assert property (@(posedge clk_sys) disable iff (srst)
    acc_start && !st.busy && is_mux && st.ctrl_b[7:6] == 2'h1 |=> ale_high2)
    else $error("latch strobe length wrong");
  latch_wave_a: assert property (@(posedge clk_sys) disable iff (srst)
    acc_start && !st.busy |=> ale_wave == $past(st.ctrl_b[5:4]))
    else $error("latch wave not captured");
  mode_order_a: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_we && cpu_addr == emicfg_pkg::ADDR_CTRL_B |=>
    ##1 iface_mode == {$past(cpu_wdata[0], 2), $past(cpu_wdata[1], 2)})
    else $error("mode bit order wrong");
  wave_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    acc_busy && cpu_we && cpu_addr == emicfg_pkg::ADDR_CTRL_A |=> $stable(rd_wave) && $stable(wr_wave))
    else $error("settings changed during access");

endmodule : emicfg_top

// ===== emicfg_mem_model.sv
/*
  Model of the external memory devices: measures the length of each
  read, write and address latch strobe pulse in clock cycles.
  Assumes registered strobes from emicfg_top sampled on clk_sys.
*/
module emicfg_mem_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ale_strobe,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  output logic [2:0][3:0] len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] act;
  logic [2:0][3:0] cnt;

  // Index 2 is the latch strobe, 1 the read strobe, 0 the write strobe.
  assign act = {ale_strobe, ~rd_strobe_n, ~wr_strobe_n};

  // Each pulse is counted while active and its length kept when it ends.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (srst)
      begin
        cnt[i] <= 4'h0;
        len[i] <= 4'h0;
      end
      else if (act[i] === 1'b1)
        cnt[i] <= cnt[i] + 4'h1;
      else if (cnt[i] != 4'h0)
      begin
        len[i] <= cnt[i];
        cnt[i] <= 4'h0;
      end
    end
  end
endmodule : emicfg_mem_model

// ===== tb_top.sv
/*
  Self-checking bench of emicfg_top with random register settings.
  Assumes the package emicfg_pkg and the memory model are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_we = 1'b0;
  logic cpu_re = 1'b0;
  logic acc_start = 1'b0;
  logic acc_write = 1'b0;
  logic [7:0] cpu_rdata, memory_bank_map, d, ra, rb, bm;
  logic acc_busy, acc_done, ale_strobe, rd_strobe_n, wr_strobe_n;
  logic [1:0] iface_mode, rd_wave, wr_wave, ale_wave, m;
  logic [2:0][3:0] len;
  int errors = 0;
  int compares = 0;
  int rs;

  // ****************************************
  // Clock, design and memory model
  // ****************************************
  always #5 clk_sys = ~clk_sys;
  emicfg_top u_dut (.clk_sys(clk_sys), .srst(srst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_rdata(cpu_rdata), .acc_start(acc_start),
    .acc_write(acc_write), .acc_busy(acc_busy), .acc_done(acc_done), .ale_strobe(ale_strobe),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .memory_bank_map(memory_bank_map),
    .iface_mode(iface_mode), .rd_wave(rd_wave), .wr_wave(wr_wave), .ale_wave(ale_wave));
  emicfg_mem_model u_mem (.clk_sys(clk_sys), .srst(srst), .ale_strobe(ale_strobe),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .len(len));

  // ****************************************
  // Bus and access tasks
  // ****************************************
  task reg_wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_we = 1'b1;
    @(negedge clk_sys);
    cpu_we = 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [15:0] a);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_re = 1'b1;
    @(negedge clk_sys);
    cpu_re = 1'b0;
    d = cpu_rdata;
  endtask : reg_rd

  // Runs one access; a second start and, with chg set, a register write land while busy.
  task access(input logic w, input logic [1:0] md, input int al, input int wt, input logic chg);
    int k;
    k = 0;
    @(negedge clk_sys);
    acc_start = 1'b1;
    acc_write = w;
    while (k < 40)
    begin
      @(negedge clk_sys);
      k++;
      acc_start = (k == 1);
      cpu_addr = emicfg_pkg::ADDR_CTRL_A;
      cpu_wdata = 8'hff;
      cpu_we = chg && (k == 1);
      if (acc_done === 1'b1)
        break;
    end
    `CHK("cycles", (md == emicfg_pkg::MODE_MUX) ? 3 + al + wt : 2 + wt, k)
    @(negedge clk_sys);
    `CHK("busy", 1'b0, acc_busy)
    `CHK("idle", 4'h3, {acc_done, ale_strobe, rd_strobe_n, wr_strobe_n})
    `CHK("strobe", 4'(wt + 1), len[w ? 0 : 1])
    if (md == emicfg_pkg::MODE_MUX)
      `CHK("ale", 4'(al + 1), len[2])
  endtask : access

  task finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rs = $urandom(9);
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    reg_rd(emicfg_pkg::ADDR_BANK_MAP);
    `CHK("bank_map", 8'h01, d)
    reg_rd(emicfg_pkg::ADDR_CTRL_A);
    `CHK("ctrl_a", 8'h00, d)
    `CHK("mode", 2'h0, iface_mode)
    reg_wr(16'hf803, 8'h5a);
    reg_rd(16'hf803);
    `CHK("unmapped", 8'h00, d)
    $display("test reset done");
    for (int i = 0; i < 20; i++)
    begin
      m = 2'(i);
      bm = 8'($urandom);
      // Fixed corners make sure every strobe length check gets exercised.
      ra = (i == 19) ? 8'hcc : (i == 0) ? 8'hb6 : (i == 4) ? 8'h71 : 8'($urandom);
      rb = {(i == 19) ? 2'h3 : (i == 3) ? 2'h1 : 2'($urandom), 2'($urandom), 2'h0, m[0], m[1]};
      reg_wr(emicfg_pkg::ADDR_BANK_MAP, bm);
      reg_wr(emicfg_pkg::ADDR_CTRL_A, ra);
      reg_wr(emicfg_pkg::ADDR_CTRL_B, rb);
      reg_rd(emicfg_pkg::ADDR_BANK_MAP);
      `CHK("bank_map", bm, d)
      `CHK("bank_out", bm, memory_bank_map)
      reg_rd(emicfg_pkg::ADDR_CTRL_A);
      `CHK("ctrl_a", ra, d)
      reg_rd(emicfg_pkg::ADDR_CTRL_B);
      `CHK("ctrl_b", rb, d)
      `CHK("mode", m, iface_mode)
      access(i[2], m, rb[7:6], i[2] ? ra[3:2] : ra[7:6], i[3]);
      `CHK("rd_wave", ra[5:4], rd_wave)
      `CHK("wr_wave", ra[1:0], wr_wave)
      `CHK("ale_wave", rb[5:4], ale_wave)
      $display("test access %0d done", i);
    end
    // A reset in mid-run must bring back every reset value after random settings.
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    reg_rd(emicfg_pkg::ADDR_BANK_MAP);
    `CHK("bank_map", emicfg_pkg::RST_BANK_MAP, d)
    reg_rd(emicfg_pkg::ADDR_CTRL_A);
    `CHK("ctrl_a", emicfg_pkg::RST_CTRL_A, d)
    reg_rd(emicfg_pkg::ADDR_CTRL_B);
    `CHK("ctrl_b", emicfg_pkg::RST_CTRL_B, d)
    `CHK("mode", emicfg_pkg::MODE_FIFO, iface_mode)
    `CHK("waves", 6'h00, {rd_wave, wr_wave, ale_wave})
    $display("test mid reset done");
    finish_test();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
endmodule : tb_top
